/* include/pei_pkg.sv */
// Constants and types of the PHY event interrupt and coding-sublayer register bank.
// Assumes one core clock; register offsets are byte addresses on the management port.
// Overview of operation
// - Link, jabber, fault, autoneg, half-full raise events
// - Test interrupt works without the event enable
// - Test bit interrupts after every management read
// - Enable bit 1 gates event-based interrupts
// - Event interrupts only when unmasked and enabled
// - Pending bit 15 read-only, cleared by its read
// - Mask bits 14..9 gate the six events
// - Reserved bits ignore writes, read zero
// - False carrier counter saturates, clears on read
// - Receive error counts invalid symbol during carrier
// - Once per carrier, never during collision
// - Receive error counter saturates, clears on read
// - Bit 12 bypasses block coding
// - Bit 11 makes receive clock free-running
// - Bit 10 enables true quiet transmit
// - Bit 9 forces signal detect
// - Bit 8 selects enhanced detect, reset 0100h
// - Bit 5 ORed into force fast link
// - Bit 2 bypasses line coding
package pei_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int CNT_W  = 8;

    localparam logic [ADDR_W-1:0] OFS_IRQ_CONTROL = 8'hc4;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS  = 8'hc8;
    localparam logic [ADDR_W-1:0] OFS_FALSE_CARR  = 8'hd0;
    localparam logic [ADDR_W-1:0] OFS_RX_ERROR    = 8'hd4;
    localparam logic [ADDR_W-1:0] OFS_CODING_CFG  = 8'hd8;

    localparam logic [DATA_W-1:0] RST_IRQ_CONTROL = 16'h0000;
    localparam logic [DATA_W-1:0] RST_IRQ_STATUS  = 16'h0000;
    localparam logic [DATA_W-1:0] RST_CODING_CFG  = 16'h0100;

    // Writable bits of the control, status and coding registers
    localparam logic [DATA_W-1:0] WMASK_CONTROL = 16'h0003;
    localparam logic [DATA_W-1:0] WMASK_STATUS  = 16'h7e00;
    localparam logic [DATA_W-1:0] WMASK_CODING  = 16'h1f24;

    localparam int BIT_TEST_IRQ   = 0;
    localparam int BIT_EVT_ENABLE = 1;
    localparam int BIT_PENDING    = 15;
    localparam int MASK_LSB       = 9;
    localparam int NUM_EVT        = 6;

    localparam int BIT_BLOCK_BYP  = 12;
    localparam int BIT_FREE_CLK   = 11;
    localparam int BIT_QUIET      = 10;
    localparam int BIT_SD_FORCE   = 9;
    localparam int BIT_SD_ALGO    = 8;
    localparam int BIT_FAST_LINK  = 5;
    localparam int BIT_NRZI_BYP   = 2;

    // Event index order matches mask order, msb first
    localparam int EVT_LINK  = 5;
    localparam int EVT_JAB   = 4;
    localparam int EVT_RF    = 3;
    localparam int EVT_ANC   = 2;
    localparam int EVT_FHALF = 1;
    localparam int EVT_RHALF = 0;

    typedef struct packed {
        logic link_up;
        logic jabber;
        logic remote_fault;
        logic autoneg_done;
    } pei_status_t;

    typedef struct packed {
        logic block_code_bypass;
        logic receive_clock_free;
        logic true_quiet_enable;
        logic signal_detect_force;
        logic signal_detect_algo_select;
        logic nrzi_bypass;
    } pei_pcs_cfg_t;

endpackage : pei_pkg

/* core/pei_edge_events.sv */
// Turns the PHY status levels into one-cycle event pulses.
// Assumes status levels come from logic on ref_clk, so no synchroniser.
`timescale 1ns/1ns
module pei_edge_events (
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    input  wire pei_pkg::pei_status_t status_in,
    output logic [3:0]                evt_pulse
);
    import pei_pkg::*;

    pei_status_t prev_r;
    logic [3:0]  evt_nxt;

    // Link reports both directions; others report assertion only
    assign evt_nxt = {status_in.link_up ^ prev_r.link_up,
                      status_in.jabber & ~prev_r.jabber,
                      status_in.remote_fault & ~prev_r.remote_fault,
                      status_in.autoneg_done & ~prev_r.autoneg_done};

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r    <= '0;
            evt_pulse <= '0;
        end else begin
            prev_r    <= status_in;
            evt_pulse <= evt_nxt;
        end
    end

endmodule : pei_edge_events

/* core/pei_sat_counter.sv */
// Saturating clear-on-read event counter with a one-shot half-full event.
// Assumes increment, read and write strobes are one-cycle pulses on ref_clk.
`timescale 1ns/1ns
module pei_sat_counter #(
    parameter int WIDTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             inc,
    input  wire logic             rd_clr,
    input  wire logic             wr,
    input  wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0]      count_r,
    output logic                  half_evt_r
);
    localparam logic [WIDTH-1:0] CNT_MAX = '1;
    localparam logic [WIDTH-1:0] ONE     = {{(WIDTH-1){1'b0}}, 1'b1};

    logic             half_seen_r;
    logic [WIDTH-1:0] base;
    logic [WIDTH-1:0] count_nxt;
    logic             half_now;

    // An increment landing on the clearing read still counts as one
    assign base      = rd_clr ? '0 : (wr ? wdata : count_r);
    assign count_nxt = (inc && base != CNT_MAX) ? base + ONE : base;
    assign half_now  = count_nxt[WIDTH-1] && !half_seen_r && !rd_clr;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r     <= '0;
            half_seen_r <= 1'b0;
            half_evt_r  <= 1'b0;
        end else begin
            count_r     <= count_nxt;
            half_seen_r <= rd_clr ? 1'b0 : (half_seen_r | half_now);
            half_evt_r  <= half_now;
        end
    end

endmodule : pei_sat_counter

/* core/pei_phy_irq_pcs_regs.sv */
// PHY event interrupt control, event masks, error counters and
// 100 Mb/s coding-sublayer configuration registers.
// Assumes the management port, status levels and receive indications
// all come from logic on ref_clk; the host interrupt status sits outside.
`timescale 1ns/1ns
module pei_phy_irq_pcs_regs #(
    parameter int CW = pei_pkg::CNT_W
) (
    input  wire logic                         ref_clk,
    input  wire logic                         rst_n,
    input  wire logic                         mgmt_sel,
    input  wire logic                         mgmt_wr,
    input  wire logic [pei_pkg::ADDR_W-1:0]   mgmt_addr,
    input  wire logic [pei_pkg::DATA_W-1:0]   mgmt_wdata,
    output logic [pei_pkg::DATA_W-1:0]        mgmt_rdata,
    output logic                              mgmt_rvalid,
    input  wire pei_pkg::pei_status_t         status_in,
    input  wire logic                         false_carrier_evt,
    input  wire logic                         carrier_valid,
    input  wire logic                         invalid_symbol,
    input  wire logic                         collision,
    input  wire logic                         mac_force_fast_link,
    output pei_pkg::pei_pcs_cfg_t             pcs_cfg,
    output logic                              fast_link_force,
    output logic                              phy_irq,
    output logic                              irq_pending_flag
);
    import pei_pkg::*;

    // Register state
    logic [DATA_W-1:0] ctrl_r;
    logic [DATA_W-1:0] mask_r;
    logic [DATA_W-1:0] coding_r;
    logic [DATA_W-1:0] rdata_r;
    logic              rvalid_r;
    logic              pending_r;
    logic              irq_r;
    logic              rx_taken_r;
    logic              coll_seen_r;

    logic [DATA_W-1:0] ctrl_nxt;
    logic [DATA_W-1:0] mask_nxt;
    logic [DATA_W-1:0] coding_nxt;
    logic [DATA_W-1:0] rdata_nxt;
    logic              pending_nxt;
    logic              irq_nxt;
    logic              rx_taken_nxt;
    logic              coll_seen_nxt;

    // Decode
    logic rd_stb;
    logic wr_stb;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_fc;
    logic hit_rx;
    logic hit_cfg;

    // Events
    logic [3:0]         status_evt;
    logic [NUM_EVT-1:0] evt_vec;
    logic [NUM_EVT-1:0] evt_mask;
    logic               fc_half;
    logic               rx_half;
    logic               evt_fire;
    logic               test_fire;
    logic               rx_err_inc;

    // Counters
    logic [CW-1:0] fc_count;
    logic [CW-1:0] rx_count;

    // Masked write: only writable bits move, reserved bits stay zero
    function automatic logic [DATA_W-1:0] wmerge(
        input logic [DATA_W-1:0] old_v,
        input logic [DATA_W-1:0] new_v,
        input logic [DATA_W-1:0] wmask
    );
        wmerge = (old_v & ~wmask) | (new_v & wmask);
    endfunction : wmerge

    // Counter value placed in the low bits, upper bits zero
    function automatic logic [DATA_W-1:0] cnt_word(input logic [CW-1:0] c);
        cnt_word = {{(DATA_W-CW){1'b0}}, c};
    endfunction : cnt_word

    assign rd_stb   = mgmt_sel && !mgmt_wr;
    assign wr_stb   = mgmt_sel && mgmt_wr;
    assign hit_ctrl = (mgmt_addr == OFS_IRQ_CONTROL);
    assign hit_stat = (mgmt_addr == OFS_IRQ_STATUS);
    assign hit_fc   = (mgmt_addr == OFS_FALSE_CARR);
    assign hit_rx   = (mgmt_addr == OFS_RX_ERROR);
    assign hit_cfg  = (mgmt_addr == OFS_CODING_CFG);

    pei_edge_events u_edges (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .status_in (status_in),
        .evt_pulse (status_evt)
    );

    // Receive error: one count per carrier, none once a collision is seen
    assign rx_err_inc = carrier_valid && invalid_symbol && !collision
                        && !coll_seen_r && !rx_taken_r;
    assign rx_taken_nxt  = carrier_valid && (rx_taken_r || rx_err_inc);
    assign coll_seen_nxt = carrier_valid && (coll_seen_r || collision);

    pei_sat_counter #(
        .WIDTH (CW)
    ) u_false_carrier (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .inc        (false_carrier_evt),
        .rd_clr     (rd_stb && hit_fc),
        .wr         (wr_stb && hit_fc),
        .wdata      (mgmt_wdata[CW-1:0]),
        .count_r    (fc_count),
        .half_evt_r (fc_half)
    );

    pei_sat_counter #(
        .WIDTH (CW)
    ) u_rx_error (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .inc        (rx_err_inc),
        .rd_clr     (rd_stb && hit_rx),
        .wr         (wr_stb && hit_rx),
        .wdata      (mgmt_wdata[CW-1:0]),
        .count_r    (rx_count),
        .half_evt_r (rx_half)
    );

    // Event vector in mask order
    assign evt_vec  = {status_evt, fc_half, rx_half};
    assign evt_mask = mask_r[MASK_LSB +: NUM_EVT];

    // Unmasked, enabled events only
    assign evt_fire = (|(evt_vec & ~evt_mask))
                      && ctrl_r[BIT_EVT_ENABLE];

    // Test interrupt fires when a read completes, enable not needed
    assign test_fire = rvalid_r && ctrl_r[BIT_TEST_IRQ];

    // Pending: set beats the clearing read of the status register
    assign pending_nxt = (evt_fire || test_fire)
                         || (pending_r && !(rd_stb && hit_stat));
    assign irq_nxt     = evt_fire || test_fire;

    // Register writes through per-register writable masks
    assign ctrl_nxt   = (wr_stb && hit_ctrl)
                        ? wmerge(ctrl_r, mgmt_wdata, WMASK_CONTROL) : ctrl_r;
    assign mask_nxt   = (wr_stb && hit_stat)
                        ? wmerge(mask_r, mgmt_wdata, WMASK_STATUS) : mask_r;
    assign coding_nxt = (wr_stb && hit_cfg)
                        ? wmerge(coding_r, mgmt_wdata, WMASK_CODING) : coding_r;

    // Read mux; the pending bit is merged live, unmapped reads give zero
    always_comb begin
        rdata_nxt = '0;
        if (hit_ctrl) begin
            rdata_nxt = ctrl_r & WMASK_CONTROL;
        end else if (hit_stat) begin
            rdata_nxt = mask_r & WMASK_STATUS;
            rdata_nxt[BIT_PENDING] = pending_r;
        end else if (hit_fc) begin
            rdata_nxt = cnt_word(fc_count);
        end else if (hit_rx) begin
            rdata_nxt = cnt_word(rx_count);
        end else if (hit_cfg) begin
            rdata_nxt = coding_r & WMASK_CODING;
        end else begin
            rdata_nxt = '0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r   <= RST_IRQ_CONTROL;
            mask_r   <= RST_IRQ_STATUS;
            coding_r <= RST_CODING_CFG;
        end else begin
            ctrl_r   <= ctrl_nxt;
            mask_r   <= mask_nxt;
            coding_r <= coding_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r  <= '0;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r  <= rd_stb ? rdata_nxt : rdata_r;
            rvalid_r <= rd_stb;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pending_r   <= 1'b0;
            irq_r       <= 1'b0;
            rx_taken_r  <= 1'b0;
            coll_seen_r <= 1'b0;
        end else begin
            pending_r   <= pending_nxt;
            irq_r       <= irq_nxt;
            rx_taken_r  <= rx_taken_nxt;
            coll_seen_r <= coll_seen_nxt;
        end
    end

    // Configuration straight from the register flops to the datapaths
    assign pcs_cfg.block_code_bypass         = coding_r[BIT_BLOCK_BYP];
    assign pcs_cfg.receive_clock_free        = coding_r[BIT_FREE_CLK];
    assign pcs_cfg.true_quiet_enable         = coding_r[BIT_QUIET];
    assign pcs_cfg.signal_detect_force       = coding_r[BIT_SD_FORCE];
    assign pcs_cfg.signal_detect_algo_select = coding_r[BIT_SD_ALGO];
    assign pcs_cfg.nrzi_bypass               = coding_r[BIT_NRZI_BYP];

    // OR with the MAC request; combinational so the MAC sees no extra lag
    assign fast_link_force = coding_r[BIT_FAST_LINK] | mac_force_fast_link;

    assign mgmt_rdata       = rdata_r;
    assign mgmt_rvalid      = rvalid_r;
    assign phy_irq          = irq_r;
    assign irq_pending_flag = pending_r;

endmodule : pei_phy_irq_pcs_regs

/* sim/pei_regs_props.sv */
// Port-level checker for the PHY event interrupt and coding-sublayer register bank.
// Assumes one clock domain; bound onto every pei_phy_irq_pcs_regs instance.
`timescale 1ns/1ns
module pei_regs_props
    import pei_pkg::*;
#(
    parameter int CW = CNT_W
) (
    input wire logic                       ref_clk,
    input wire logic                       rst_n,
    input wire logic                       mgmt_sel,
    input wire logic                       mgmt_wr,
    input wire logic [pei_pkg::ADDR_W-1:0] mgmt_addr,
    input wire logic [pei_pkg::DATA_W-1:0] mgmt_wdata,
    input wire logic [pei_pkg::DATA_W-1:0] mgmt_rdata,
    input wire logic                       mgmt_rvalid,
    input wire logic                       mac_force_fast_link,
    input wire pei_pkg::pei_pcs_cfg_t      pcs_cfg,
    input wire logic                       fast_link_force,
    input wire logic                       phy_irq,
    input wire logic                       irq_pending_flag
);
    // Shadows of the control test bit and the coding word, so outputs can be tied to them
    logic              test_r;
    logic [DATA_W-1:0] cfg_r;
    wire               rd_take = mgmt_sel && !mgmt_wr;
    wire               wr_ctl  = mgmt_sel && mgmt_wr && mgmt_addr == OFS_IRQ_CONTROL;
    wire               wr_cfg  = mgmt_sel && mgmt_wr && mgmt_addr == OFS_CODING_CFG;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            test_r <= 1'b0;
            cfg_r  <= RST_CODING_CFG;
        end else begin
            if (wr_ctl) test_r <= mgmt_wdata[BIT_TEST_IRQ];
            if (wr_cfg) cfg_r <= mgmt_wdata;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_read_answer: assert property (rd_take |=> mgmt_rvalid)
        else $error("read not answered next cycle");
    a_no_stray_answer: assert property (mgmt_rvalid |-> $past(rd_take))
        else $error("read answer without a read");
    a_test_irq_read: assert property (rd_take && test_r |-> ##2 phy_irq)
        else $error("test interrupt missing after read");
    a_pending_readback: assert property (mgmt_rvalid && $past(mgmt_addr) == OFS_IRQ_STATUS
        |-> mgmt_rdata[15] == $past(irq_pending_flag) && mgmt_rdata[8:0] == 9'h000)
        else $error("status readback wrong");
    a_ctrl_reserved: assert property (mgmt_rvalid && $past(mgmt_addr) == OFS_IRQ_CONTROL
        |-> mgmt_rdata[15:2] == 14'h0000)
        else $error("control reserved bits not zero");
    a_cnt_reserved: assert property (mgmt_rvalid && ($past(mgmt_addr) == OFS_FALSE_CARR
        || $past(mgmt_addr) == OFS_RX_ERROR) |-> mgmt_rdata[15:8] == 8'h00)
        else $error("counter reserved bits not zero");
    a_irq_marks_pending: assert property (phy_irq |-> irq_pending_flag)
        else $error("interrupt without pending flag");
    a_pending_sticky: assert property ($past(irq_pending_flag)
        && !$past(rd_take && mgmt_addr == OFS_IRQ_STATUS) |-> irq_pending_flag)
        else $error("pending dropped without a status read");
    a_pcs_cfg_map: assert property (pcs_cfg == {cfg_r[12:8], cfg_r[2]})
        else $error("coding outputs differ from register");
    a_fast_link_or: assert property (fast_link_force == (cfg_r[5] || mac_force_fast_link))
        else $error("fast link force not an OR");

    c_test_irq: cover property (rd_take && test_r ##2 phy_irq);
    c_pending_read: cover property (mgmt_rvalid && mgmt_rdata[15]);
    c_pending_rise: cover property ($rose(irq_pending_flag));
endmodule : pei_regs_props

bind pei_phy_irq_pcs_regs pei_regs_props #(.CW(CW)) u_props (
    .ref_clk(ref_clk), .rst_n(rst_n), .mgmt_sel(mgmt_sel), .mgmt_wr(mgmt_wr),
    .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
    .mgmt_rvalid(mgmt_rvalid), .mac_force_fast_link(mac_force_fast_link), .pcs_cfg(pcs_cfg),
    .fast_link_force(fast_link_force), .phy_irq(phy_irq), .irq_pending_flag(irq_pending_flag)
);

/* sim/phy_event_irq_and_pcs_config_tb.sv */
// Self-checking bench for the PHY event interrupt and coding-sublayer register bank.
// Assumes the checker is bound in its own file; the bench drives every input.
`timescale 1ns/1ns
`define CHK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin \
    failures++; $display("FAIL %0t %s", $time, msg); end end
module phy_event_irq_and_pcs_config_tb;
    import pei_pkg::*;
    logic              ref_clk = 1'b0;
    logic              rst_n   = 1'b0;
    logic              sel = 1'b0, wr = 1'b0, fc = 1'b0, carr = 1'b0, inv = 1'b0;
    logic              coll = 1'b0, mac_fl = 1'b0;
    logic [ADDR_W-1:0] addr  = 8'h00;
    logic [DATA_W-1:0] wdata = 16'h0000;
    logic [DATA_W-1:0] rdata, rdat;
    logic              rvalid, fl_force, irq, pend;
    pei_status_t       st = '0;
    pei_pcs_cfg_t      cfg;
    int                failures = 0, n_checks = 0, k;

    pei_phy_irq_pcs_regs #(.CW(CNT_W)) dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .mgmt_sel(sel), .mgmt_wr(wr), .mgmt_addr(addr),
        .mgmt_wdata(wdata), .mgmt_rdata(rdata), .mgmt_rvalid(rvalid), .status_in(st),
        .false_carrier_evt(fc), .carrier_valid(carr), .invalid_symbol(inv), .collision(coll),
        .mac_force_fast_link(mac_fl), .pcs_cfg(cfg), .fast_link_force(fl_force),
        .phy_irq(irq), .irq_pending_flag(pend)
    );

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    // One access per call, leaving an idle cycle so strobes never toggle twice in a step
    task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        #1;
        sel = 1'b1;
        wr = w;
        addr = a;
        wdata = d;
        @(posedge ref_clk);
        #1;
        sel = 1'b0;
        rdat = rdata;
        if (!w) `CHK(rvalid, 1'b1, "read not answered")
    endtask : acc

    task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
        acc(1'b0, a, 16'h0000);
        `CHK(rdat, e, "read value")
    endtask : chk_rd

    task automatic watch(input int n);
        k = 0;
        repeat (n) begin
            @(posedge ref_clk);
            #1;
            // An unknown counts as a hit so that it can never pass as quiet
            if (irq !== 1'b0) k++;
        end
    endtask : watch

    task automatic t_reset;
        chk_rd(OFS_IRQ_CONTROL, 16'h0000);
        chk_rd(OFS_IRQ_STATUS, 16'h0000);
        chk_rd(OFS_FALSE_CARR, 16'h0000);
        chk_rd(OFS_RX_ERROR, 16'h0000);
        chk_rd(OFS_CODING_CFG, 16'h0100);
        `CHK(cfg, 6'h02, "reset coding outputs")
    endtask : t_reset

    task automatic t_regs;
        acc(1'b1, OFS_IRQ_STATUS, 16'hffff);
        chk_rd(OFS_IRQ_STATUS, 16'h7e00);
        acc(1'b1, OFS_IRQ_STATUS, 16'h0000);
        acc(1'b1, OFS_CODING_CFG, 16'hffff);
        chk_rd(OFS_CODING_CFG, 16'h1f24);
        `CHK(cfg, 6'h3f, "coding outputs all set")
        `CHK(fl_force, 1'b1, "coding bit forces fast link")
        acc(1'b1, OFS_CODING_CFG, 16'h0000);
        `CHK(cfg, 6'h00, "coding outputs clear")
        `CHK(fl_force, 1'b0, "fast link idle")
        mac_fl = 1'b1;
        @(posedge ref_clk);
        #1 `CHK(fl_force, 1'b1, "mac force passes")
        mac_fl = 1'b0;
        acc(1'b1, OFS_FALSE_CARR, 16'hff55);
        chk_rd(OFS_FALSE_CARR, 16'h0055);
        acc(1'b1, OFS_IRQ_CONTROL, 16'hfffe);
        chk_rd(OFS_IRQ_CONTROL, 16'h0002);
        acc(1'b1, 8'hc0, 16'hffff);
        chk_rd(8'hc0, 16'h0000);
    endtask : t_regs

    task automatic t_test;
        acc(1'b1, OFS_IRQ_CONTROL, 16'h0001);
        chk_rd(OFS_CODING_CFG, 16'h0000);
        watch(3);
        `CHK(k, 1, "test interrupt count")
        `CHK(pend, 1'b1, "test interrupt pending")
        acc(1'b1, OFS_IRQ_CONTROL, 16'h0000);
        chk_rd(OFS_IRQ_STATUS, 16'h8000);
        `CHK(pend, 1'b0, "pending cleared by read")
        chk_rd(OFS_IRQ_STATUS, 16'h0000);
    endtask : t_test

    // Each of the four status sources raised unmasked then masked; link must also fire on its fall
    task automatic t_evt;
        logic [15:0] msk;
        acc(1'b1, OFS_IRQ_CONTROL, 16'h0002);
        for (int m = 0; m < 2; m++) begin
            for (int i = 0; i < 4; i++) begin
                msk = (m != 0) ? (16'h0800 << i) : 16'h0000;
                acc(1'b1, OFS_IRQ_STATUS, msk);
                st[i] = 1'b1;
                watch(4);
                `CHK(k, (m == 0) ? 1 : 0, "rise interrupt count")
                chk_rd(OFS_IRQ_STATUS, msk | ((m == 0) ? 16'h8000 : 16'h0000));
                st[i] = 1'b0;
                watch(4);
                `CHK(k, (i == 3 && m == 0) ? 1 : 0, "fall interrupt count")
                acc(1'b0, OFS_IRQ_STATUS, 16'h0000);
            end
        end
        acc(1'b1, OFS_IRQ_STATUS, 16'h0000);
        acc(1'b1, OFS_IRQ_CONTROL, 16'h0000);
        st[3] = 1'b1;
        watch(4);
        `CHK(k, 0, "event with enable off")
        chk_rd(OFS_IRQ_STATUS, 16'h0000);
        st[3] = 1'b0;
        acc(1'b1, OFS_IRQ_CONTROL, 16'h0002);
        acc(1'b0, OFS_IRQ_STATUS, 16'h0000);
    endtask : t_evt

    task automatic pulses(input int n);
        fc = 1'b1;
        repeat (n) @(posedge ref_clk);
        #1 fc = 1'b0;
    endtask : pulses

    task automatic t_fc;
        pulses(128);
        watch(4);
        `CHK(k, 1, "half-full interrupt")
        pulses(130);
        watch(4);
        `CHK(k, 0, "half-full not repeated")
        chk_rd(OFS_FALSE_CARR, 16'h00ff);
        chk_rd(OFS_FALSE_CARR, 16'h0000);
        pulses(128);
        watch(4);
        `CHK(k, 1, "half-full re-armed by read")
        acc(1'b0, OFS_FALSE_CARR, 16'h0000);
        acc(1'b0, OFS_IRQ_STATUS, 16'h0000);
        acc(1'b1, OFS_IRQ_STATUS, 16'h0400);
        pulses(128);
        watch(4);
        `CHK(k, 0, "masked half-full")
        chk_rd(OFS_IRQ_STATUS, 16'h0400);
        acc(1'b1, OFS_IRQ_STATUS, 16'h0000);
        acc(1'b0, OFS_FALSE_CARR, 16'h0000);
    endtask : t_fc

    task automatic t_rx;
        inv = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 carr = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 inv = 1'b0;
        carr = 1'b0;
        @(posedge ref_clk);
        #1 carr = 1'b1;
        coll = 1'b1;
        inv = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 inv = 1'b0;
        coll = 1'b0;
        carr = 1'b0;
        chk_rd(OFS_RX_ERROR, 16'h0001);
        chk_rd(OFS_RX_ERROR, 16'h0000);
        repeat (260) begin
            @(posedge ref_clk);
            #1 carr = ~carr;
            inv = carr;
        end
        chk_rd(OFS_IRQ_STATUS, 16'h8000);
        chk_rd(OFS_RX_ERROR, 16'h0082);
        carr = 1'b0;
        inv = 1'b0;
    endtask : t_rx

    // A reset in mid-run must bring every register back to its reset word
    task automatic t_rst2;
        acc(1'b1, OFS_CODING_CFG, 16'h1224);
        acc(1'b1, OFS_IRQ_STATUS, 16'h7e00);
        acc(1'b1, OFS_IRQ_CONTROL, 16'h0003);
        acc(1'b0, OFS_IRQ_STATUS, 16'h0000);
        @(posedge ref_clk);
        #1 `CHK(pend, 1'b1, "pending before reset")
        rst_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        `CHK(pend, 1'b0, "pending after reset")
        `CHK(irq, 1'b0, "interrupt after reset")
        t_reset();
    endtask : t_rst2

    task automatic give_verdict;
        if (failures == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (12) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        t_reset();
        t_regs();
        t_test();
        t_evt();
        t_fc();
        t_rx();
        t_rst2();
        give_verdict();
    end

    // The whole run needs about 1,000 cycles; twenty times that means a hang
    initial begin
        #80000;
        failures++;
        give_verdict();
    end
endmodule : phy_event_irq_and_pcs_config_tb
